/* core_timer_pkg.sv */
// constants and carriers shared by the core tick timer
package core_timer_pkg;
    localparam int TIMER_WIDTH = 32;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] MATCH_RESET = 32'hFFFF_FFFF;
    localparam logic PHASE_RESET = 1'b0;
    localparam logic [31:0] COUNT_STEP = 32'h0000_0001;

    typedef struct packed {
        logic write_count;
        logic write_match;
        logic [31:0] data;
    } sw_write_t;

    typedef struct packed {
        logic [31:0] count;
        logic [31:0] match;
    } timer_view_t;
endpackage

/* core_timer.sv */
// core tick timer with match request toward the interrupt controller
`timescale 1ns/1ps
// How it works
// - two software registers: running tick count and match value, both readable and writable
// - count steps once every two system clock cycles via an internal enable
// - optional freeze of counting while the core is in debug mode
// - count equal to match raises the timer request
module core_timer (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire core_timer_pkg::sw_write_t SW_WRITE,
    input wire logic DEBUG_MODE,
    input wire logic FREEZE_IN_DEBUG,
    output core_timer_pkg::timer_view_t TIMER_VIEW,
    output logic TIMER_REQ
);
    import core_timer_pkg::*;

    logic [TIMER_WIDTH-1:0] count_reg;
    logic [TIMER_WIDTH-1:0] match_reg;
    logic phase_reg;
    logic req_reg;
    logic frozen;
    logic tick;
    logic hit;

    function automatic logic [TIMER_WIDTH-1:0] next_count(input logic [TIMER_WIDTH-1:0] value);
        return value + COUNT_STEP;
    endfunction

    sequence s_count_tick;
        tick && !SW_WRITE.write_count;
    endsequence

    sequence s_match_clear;
        SW_WRITE.write_match && !hit;
    endsequence

    sequence s_running2;
        !frozen ##1 !frozen;
    endsequence

    sequence s_free4;
        (!frozen && !SW_WRITE.write_count) [*4];
    endsequence

    sequence s_unfreeze;
        frozen ##1 !frozen [*2];
    endsequence

    // freeze only while both the option and debug are present
    assign frozen = FREEZE_IN_DEBUG && DEBUG_MODE;
    // divide-by-two enable keeps a single clock domain
    assign tick = phase_reg && !frozen;
    assign hit = (count_reg == match_reg);

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            phase_reg <= PHASE_RESET;
        end else if (!frozen) begin
            phase_reg <= !phase_reg;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            count_reg <= COUNT_RESET;
        end else if (SW_WRITE.write_count) begin
            count_reg <= SW_WRITE.data;
        end else if (tick) begin
            count_reg <= next_count(count_reg);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            match_reg <= MATCH_RESET;
        end else if (SW_WRITE.write_match) begin
            match_reg <= SW_WRITE.data;
        end
    end

    // a fresh hit wins over the clearing match write
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            req_reg <= 1'b0;
        end else if (hit) begin
            req_reg <= 1'b1;
        end else if (SW_WRITE.write_match) begin
            req_reg <= 1'b0;
        end
    end

    // the controller alone decides whether the request is taken
    assign TIMER_REQ = req_reg;
    assign TIMER_VIEW.count = count_reg;
    assign TIMER_VIEW.match = match_reg;

    a_count_step: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_count_tick |=> (count_reg == next_count($past(count_reg))))
        else $error("count did not step on tick");
    a_tick_spacing: assert property (@(posedge CORE_CLK) disable iff (RST)
        tick |=> !tick)
        else $error("ticks on adjacent cycles");
    a_debug_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
        (frozen && !SW_WRITE.write_count) |=> $stable(count_reg))
        else $error("count moved while frozen");
    a_match_raise: assert property (@(posedge CORE_CLK) disable iff (RST)
        hit |=> TIMER_REQ)
        else $error("match did not raise request");
    a_req_pending: assert property (@(posedge CORE_CLK) disable iff (RST)
        (TIMER_REQ && !SW_WRITE.write_match) |=> TIMER_REQ)
        else $error("request dropped without match write");
    a_req_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_match_clear |=> !TIMER_REQ)
        else $error("match write did not clear request");
    a_count_write: assert property (@(posedge CORE_CLK) disable iff (RST)
        SW_WRITE.write_count |=> (TIMER_VIEW.count == $past(SW_WRITE.data)))
        else $error("count write lost");
    a_match_write: assert property (@(posedge CORE_CLK) disable iff (RST)
        SW_WRITE.write_match |=> (TIMER_VIEW.match == $past(SW_WRITE.data)))
        else $error("match write lost");

    a_reset_count: assert property (
        @(posedge CORE_CLK)
        RST
        |=> (count_reg == COUNT_RESET))
        else $error("count not cleared by reset");

    a_reset_match: assert property (
        @(posedge CORE_CLK)
        RST
        |=> (match_reg == MATCH_RESET))
        else $error("match not set by reset");

    a_reset_req: assert property (
        @(posedge CORE_CLK)
        RST
        |=> !TIMER_REQ)
        else $error("request not cleared by reset");

    a_reset_phase: assert property (
        @(posedge CORE_CLK)
        RST
        |=> (phase_reg == PHASE_RESET))
        else $error("divider phase not cleared by reset");

    a_phase_toggle: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !frozen
        |=> (phase_reg != $past(phase_reg)))
        else $error("divider phase did not toggle");

    a_phase_hold: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        frozen
        |=> $stable(phase_reg))
        else $error("divider phase moved while frozen");

    a_count_idle: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!tick && !SW_WRITE.write_count)
        |=> $stable(count_reg))
        else $error("count moved without tick");

    a_count_wrap: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (s_count_tick and (count_reg == '1))
        |=> (count_reg == '0))
        else $error("count did not wrap to zero");

    a_match_hold: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !SW_WRITE.write_match
        |=> $stable(match_reg))
        else $error("match moved without write");

    a_req_cause: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $rose(TIMER_REQ)
        |-> $past(hit))
        else $error("request rose without a match");

    a_set_wins: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (hit && SW_WRITE.write_match)
        |=> TIMER_REQ)
        else $error("match write beat a fresh hit");

    a_req_quiet: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!hit && !TIMER_REQ)
        |=> !TIMER_REQ)
        else $error("request rose without cause");

    a_tick_alternate: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        s_running2
        |-> (tick != $past(tick)))
        else $error("tick did not alternate while running");

    a_count_rate: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        s_free4
        |=> (count_reg == next_count(next_count($past(count_reg, 4)))))
        else $error("count rate is not half the clock");

    a_freeze_resume: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        s_unfreeze
        |-> (tick || $past(tick)))
        else $error("count did not resume after debug");

    a_debug_runs: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (DEBUG_MODE && !FREEZE_IN_DEBUG)
        |=> (phase_reg != $past(phase_reg)))
        else $error("divider held in debug without option");

    a_both_writes: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (SW_WRITE.write_count && SW_WRITE.write_match)
        |=> ((count_reg == $past(SW_WRITE.data)) && (match_reg == $past(SW_WRITE.data))))
        else $error("joint write lost");

    a_write_beats_tick: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (SW_WRITE.write_count && tick)
        |=> (count_reg == $past(SW_WRITE.data)))
        else $error("tick beat count write");
endmodule

/* irq_ctrl_model.sv */
// interrupt controller model that takes the timer request
`timescale 1ns/1ps
module irq_ctrl_model (
    input wire logic CORE_CLK,
    input wire logic SRC_EN,
    input wire logic TIMER_REQ,
    output logic TAKEN
);
    always_ff @(posedge CORE_CLK) begin
        TAKEN <= TIMER_REQ & SRC_EN;
    end
endmodule

/* test_core_timer.sv */
// testbench for the core tick timer
`timescale 1ns/1ps
module test_core_timer;
    import core_timer_pkg::*;
    logic clk = 0, rst = 1, dbg = 0, frz = 0, en = 0, req, taken;
    sw_write_t sw = '0;
    timer_view_t v;
    int num_errors = 0, compares = 0, cycles = 0;
    logic [31:0] c0;
    core_timer dut (.CORE_CLK(clk), .RST(rst), .SW_WRITE(sw), .DEBUG_MODE(dbg),
        .FREEZE_IN_DEBUG(frz), .TIMER_VIEW(v), .TIMER_REQ(req));
    irq_ctrl_model irq (.CORE_CLK(clk), .SRC_EN(en), .TIMER_REQ(req), .TAKEN(taken));
    initial forever #10 clk = ~clk;
    task automatic end_sim;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 400) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    // strobe for one edge; released on the write edge so back to back calls never collide
    task automatic wr(input logic [1:0] s, input logic [31:0] d);
        sw = {s, d};
        @(posedge clk) sw <= '0;
        @(negedge clk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    initial begin
        cyc(3);
        rst = 0;
        chk("count", v.count, 32'h0);
        chk("match", v.match, 32'hFFFFFFFF);
        cyc(4);
        chk("count", v.count, 32'h2);
        wr(2'b01, 32'h1);
        wr(2'b10, 32'hFFFFFFFF);
        chk("count", v.count, 32'hFFFFFFFF);
        for (int i = 0; i < 10 && req !== 1'b1; i++) @(negedge clk);
        chk("req", req, 1);
        chk("count", v.count, 32'h1);
        cyc(2);
        chk("taken", taken, 0);
        en = 1;
        cyc(2);
        chk("taken", taken, 1);
        chk("req", req, 1);
        wr(2'b01, 32'hFFFFFFFF);
        chk("req", req, 0);
        cyc(2);
        chk("taken", taken, 0);
        frz = 1;
        dbg = 1;
        c0 = v.count;
        cyc(6);
        chk("count", v.count, c0);
        dbg = 0;
        cyc(4);
        chk("count", v.count, c0 + 32'h2);
        frz = 0;
        dbg = 1;
        c0 = v.count;
        cyc(4);
        chk("count", v.count, c0 + 32'h2);
        dbg = 0;
        wr(2'b11, 32'h5);
        chk("count", v.count, 32'h5);
        chk("match", v.match, 32'h5);
        cyc(1);
        chk("req", req, 1);
        end_sim();
    end
endmodule
